// ==== dv/iah_host.sv ====
// iah_host: behavioural host processor on the strobe bus
// assumes: shares mclk with the device, moves strobes on the falling edge
`timescale 1ns/1ps
`default_nettype none
module iah_host (
    input  wire logic              mclk,
    input  wire logic [7:0]        db_out,
    input  wire logic              db_oe,
    output var iah_pkg::iah_pins_t pins
);
    import iah_pkg::*;
    logic       a0 = 1'b1, wr_n = 1'b1, rd_n = 1'b1, cs_n = 1'b1, h_oe = 1'b0;
    logic [7:0] h_d = 8'h00, last_db = 8'h00, bus;
    // a released bus toggles every cycle, never keeps the last value
    assign bus  = h_oe ? h_d : ((db_oe === 1'b1) ? db_out : ~last_db);
    assign pins = {a0, wr_n, rd_n, cs_n, bus};
    always @(posedge mclk) last_db <= (h_oe || db_oe === 1'b1) ? bus : ~last_db;
    // one instruction: 6 cycles low, data held 2 cycles past release
    task automatic cyc(input logic a, input logic w, input logic [7:0] d,
                       input logic r, output logic [7:0] q);
        @(negedge mclk);
        a0 = a;
        h_d = d;
        h_oe = ~w;
        cs_n = 1'b0;
        wr_n = w;
        rd_n = r;
        repeat (6) @(negedge mclk);
        q = db_out;
        wr_n = 1'b1;
        rd_n = 1'b1;
        cs_n = 1'b1;
        repeat (2) @(negedge mclk);
        h_oe = 1'b0;
        repeat (3) @(negedge mclk);
    endtask : cyc
endmodule : iah_host
`default_nettype wire

// ==== dv/iah_top_tb.sv ====
// iah_top_tb: self-checking bench of the host port
// assumes: iah_host drives the host pins, the bench drives sp and lk_addr
`timescale 1ns/1ps
`default_nettype none
module iah_top_tb;
    import iah_pkg::*;
    logic       mclk = 1'b0, rst_n = 1'b0, sp = 1'b0;
    logic [7:0] lk_addr = 8'h00, db_out, clk_shift, q;
    logic [3:0] op_mode;
    logic       db_oe, tri_sel, standby, clk_sel, config_std, in_frame, out_frame, synced;
    iah_pins_t  pins;
    iah_lk_t    lk;
    int         err_count = 0, samples_checked = 0, n_in = 0, n_out = 0;
    logic [7:0] ad [6];
    logic [9:0] wd [6];

    iah_host iah_host_inst (.mclk(mclk), .db_out(db_out), .db_oe(db_oe), .pins(pins));
    iah_top iah_top_inst (
        .mclk(mclk), .rst_n(rst_n), .pins(pins), .sp(sp), .lk_addr(lk_addr),
        .db_out(db_out), .db_oe(db_oe), .op_mode(op_mode), .tri_sel(tri_sel),
        .standby(standby), .clk_sel(clk_sel), .config_std(config_std),
        .clk_shift(clk_shift), .lk(lk), .in_frame(in_frame), .out_frame(out_frame),
        .synced(synced)
    );

    initial begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (in_frame === 1'b1) n_in <= n_in + 1;
        if (out_frame === 1'b1) n_out <= n_out + 1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t byte got %h exp %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk10(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk10
    function automatic logic [7:0] exp_ctl(input logic [7:0] c, input logic [1:0] lo);
        return CTRL_ONES | (c & 8'h30) | {6'h00, lo};
    endfunction : exp_ctl
    task automatic wr(input logic a, input logic [7:0] d);
        iah_host_inst.cyc(a, 1'b0, d, 1'b1, q);
    endtask : wr
    task automatic rd(input logic a);
        iah_host_inst.cyc(a, 1'b1, 8'h00, 1'b0, q);
    endtask : rd
    // poll status until both busy flags are clear
    task automatic idle();
        for (int i = 0; i < 40; i++) begin
            rd(1'b0);
            if (q[7:6] === 2'b00) return;
        end
        err_count++;
        $display("ERROR %0t busy never cleared", $time);
        conclude();
    endtask : idle
    task automatic ia_seq(input logic [7:0] c, input logic [7:0] d, input logic [7:0] a);
        idle();
        wr(1'b1, c);
        rd(1'b0);
        chk8({7'h00, q[6]}, 8'h01);
        wr(1'b1, d);
        wr(1'b1, a);
        idle();
    endtask : ia_seq
    task automatic ia_read(input logic [7:0] c, input logic [7:0] a,
                           input logic [7:0] ec, input logic [7:0] ed);
        ia_seq(c, 8'($urandom), a);
        rd(1'b1);
        chk8(q, ec);
        rd(1'b0);
        chk8({7'h00, q[6]}, 8'h01);
        rd(1'b1);
        chk8(q, ed);
        rd(1'b1);
        chk8(q, a);
        idle();
    endtask : ia_read
    task automatic done(input string t);
        $display("test %s done", t);
    endtask : done
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        $display("ERROR %0t run limit reached", $time);
        conclude();
    end
    initial begin
        void'($urandom(32'h04ED));
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        chk8({op_mode, tri_sel, standby, clk_sel, config_std}, 8'hFF);
        chk8(clk_shift, 8'h00);
        rd(1'b0);
        chk8(q & 8'h7F, 8'h20);
        done("reset");
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            sp = 1'b1;
            repeat (7) @(negedge mclk);
            sp = 1'b0;
            repeat (40) @(negedge mclk);
            if (i == 1) chk8({7'h00, synced}, 8'h00);
        end
        chk8({7'h00, synced}, 8'h01);
        chk8(8'(n_in), 8'h04);
        chk8(8'(n_out), 8'h03);
        rd(1'b0);
        chk8(q & 8'h7F, 8'h00);
        done("sync");
        wr(1'b0, 8'hA8);
        chk8({op_mode, tri_sel, standby, 2'b00}, 8'hA8);
        rd(1'b0);
        chk8({7'h00, q[7]}, 8'h01);
        idle();
        lk_addr = 8'hE5;
        repeat (2) @(negedge mclk);
        chk10(lk.word, CM_HIZ);
        chk8({7'h00, lk.hiz}, 8'h01);
        done("clear");
        for (int i = 0; i < 6; i++) begin
            ad[i] = {i[2:0], 5'($urandom)};
            wd[i] = (i == 0) ? CM_HIZ : 10'($urandom);
            ia_seq({2'b00, (i[0] ? 2'b01 : 2'b10), 2'b00, wd[i][9:8]}, wd[i][7:0], ad[i]);
        end
        for (int i = 0; i < 6; i++) begin
            lk_addr = ad[i];
            repeat (2) @(negedge mclk);
            chk10(lk.word, wd[i]);
            chk8({7'h00, lk.hiz}, {7'h00, wd[i] == CM_HIZ});
        end
        for (int i = 0; i < 3; i++) begin
            ia_read((i == 1) ? 8'hCC : 8'h00, ad[i], exp_ctl(8'h00, wd[i][9:8]), wd[i][7:0]);
        end
        done("memory");
        ia_seq(8'h30, 8'h00, CFR_SEL);
        chk8({6'h00, clk_sel, config_std}, 8'h00);
        ia_seq(8'h30, 8'h55, CSR_SEL);
        chk8(clk_shift, 8'h55);
        ia_read(8'h31, CSR_SEL, exp_ctl(8'h31, 2'b11), 8'h55);
        ia_read(8'h31, CFR_SEL, exp_ctl(8'h31, 2'b11), CFR_ONES);
        ia_read(8'h31, 8'h10, exp_ctl(8'h31, 2'b11), 8'h00);
        ia_seq(8'h30, 8'h03, CFR_SEL);
        chk8({6'h00, clk_sel, config_std}, 8'h03);
        chk8(clk_shift, 8'h00);
        done("registers");
        wr(1'b1, 8'h31);
        rd(1'b0);
        chk8({7'h00, q[6]}, 8'h01);
        wr(1'b0, 8'hA6);
        rd(1'b0);
        chk8(q & 8'h7F, 8'h00);
        wr(1'b0, 8'hA4);
        chk8({op_mode, tri_sel, standby, 2'b00}, 8'hA0);
        ia_read(8'h31, CSR_SEL, exp_ctl(8'h31, 2'b11), 8'h00);
        done("abort");
        iah_host_inst.cyc(1'b0, 1'b0, 8'h00, 1'b0, q);
        chk8({op_mode, tri_sel, standby, clk_sel, config_std}, 8'hFF);
        chk8(clk_shift, 8'h00);
        done("software reset");
        conclude();
    end
endmodule : iah_top_tb
`default_nettype wire

// ==== rtl/iah_cm.sv ====
// iah_cm: connection memory in flip-flops with clear engine
// assumes: one write, one host read and one lookup port per cycle
`timescale 1ns/1ps
`default_nettype none
module iah_cm #(
    parameter int DEPTH = iah_pkg::CM_DEPTH
) (
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire logic            we,
    input  wire logic [7:0]      waddr,
    input  wire logic [9:0]      wdata,
    input  wire logic            clr,
    input  wire logic [7:0]      raddr,
    output logic [9:0]           rdata,
    input  wire logic [7:0]      lk_addr,
    output iah_pkg::iah_lk_t     lk,
    output logic                 busy
);
    import iah_pkg::*;
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || DEPTH > 256 || (1 << AW) != DEPTH) begin : g_chk
        $error("connection memory depth must be a power of two up to 256");
    end

    typedef struct packed {
        logic [DEPTH-1:0][9:0] mem;
        logic [9:0]            rd;
        iah_lk_t               lk;
        logic                  busy;
        logic [AW-1:0]         ccnt;
    } iah_cm_st_t;

    iah_cm_st_t st_r;
    iah_cm_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (st_r.busy) begin
            st_nxt.mem[st_r.ccnt] = CM_HIZ;
            st_nxt.ccnt = st_r.ccnt + 1'b1;
            st_nxt.busy = (st_r.ccnt != AW'(DEPTH - 1));
        end else if (clr) begin
            st_nxt.busy = 1'b1;
            st_nxt.ccnt = '0;
        end else if (we) begin
            st_nxt.mem[waddr[AW-1:0]] = wdata;
        end
        st_nxt.rd = st_r.mem[raddr[AW-1:0]];
        st_nxt.lk.word = st_r.mem[lk_addr[AW-1:0]];
        st_nxt.lk.hiz = (st_r.mem[lk_addr[AW-1:0]] == CM_HIZ);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rd;
    assign lk    = st_r.lk;
    assign busy  = st_r.busy;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_hiz_lookup: assert property (st_r.mem[lk_addr[AW-1:0]] == 10'h200 |=> lk.hiz)
        else $error("tristate entry not flagged");
    a_clear_ends: assert property ($rose(st_r.busy) |-> ##[1:256] !st_r.busy)
        else $error("memory clear did not end");
endmodule : iah_cm
`default_nettype wire

// ==== rtl/iah_pkg.sv ====
// iah_pkg: constants and types of the indirect access host port
// assumes: mclk at 10 MHz, 8-bit host bus with one address bit
package iah_pkg;
    localparam int CLK_NS      = 100;
    localparam int ACCESS_NS   = 900;
    localparam int ACCESS_CYC  = ACCESS_NS / CLK_NS;
    localparam int LEAD_NS     = 244;
    localparam int LEAD_CYC    = LEAD_NS / CLK_NS;
    localparam int SYNC_PULSES = 3;
    localparam int CM_DEPTH    = 256;
    localparam int CM_W        = 10;

    localparam logic [7:0] CFR_SEL   = 8'hFE;
    localparam logic [7:0] CSR_SEL   = 8'hFF;
    localparam logic [7:0] MODE_RST  = 8'hFF;
    localparam logic [7:0] CFR_RST   = 8'hFF;
    localparam logic [7:0] CSR_RST   = 8'h00;
    localparam logic [7:0] CFR_ONES  = 8'hFC;
    localparam logic [7:0] CTRL_ONES = 8'hCC;
    localparam logic [9:0] CM_HIZ    = 10'h200;

    localparam int MODE_STBY = 0;
    localparam int MODE_RI   = 1;
    localparam int MODE_RC   = 2;
    localparam int MODE_TRI  = 3;
    localparam int MODE_SEL  = 4;
    localparam int CFR_CFS   = 0;
    localparam int CFR_CLK   = 1;
    localparam int CTL_C0    = 0;
    localparam int CTL_K0    = 4;
    localparam int CTL_K1    = 5;

    typedef enum logic [2:0] {
        IA_IDLE = 3'b000,
        IA_WDAT = 3'b001,
        IA_WADR = 3'b011,
        IA_ACC  = 3'b010,
        IA_RCTL = 3'b110,
        IA_RDAT = 3'b111,
        IA_RADR = 3'b101,
        IA_REC  = 3'b100
    } iah_ia_t;

    typedef struct packed {
        logic       a0;
        logic       wr_n;
        logic       rd_n;
        logic       cs_n;
        logic [7:0] db;
    } iah_pins_t;

    typedef struct packed {
        logic [9:0] word;
        logic       hiz;
    } iah_lk_t;
endpackage : iah_pkg

// ==== rtl/iah_sync.sv ====
// iah_sync: sync pulse tracking and frame start pulses
// assumes: sp is an asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module iah_sync (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic sp,
    output logic      in_frame,
    output logic      out_frame,
    output logic      synced
);
    import iah_pkg::*;

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        s3;
        logic [1:0]  npulse;
        logic [11:0] hcnt;
        logic [11:0] hlen;
        logic        inf;
        logic        outf;
        logic        sy;
    } iah_sync_st_t;

    iah_sync_st_t st_r;
    iah_sync_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = sp;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.inf = st_r.s2 & ~st_r.s3;
        st_nxt.outf = st_r.s2 && (st_r.hlen > 12'(LEAD_CYC))
                   && (st_r.hcnt == st_r.hlen - 12'(LEAD_CYC));
        if (st_r.s2) begin
            st_nxt.hcnt = st_r.hcnt + 12'h001;
        end
        if (~st_r.s2 & st_r.s3) begin
            st_nxt.hlen = st_r.hcnt;
            st_nxt.hcnt = 12'h000;
            if (st_r.npulse != 2'(SYNC_PULSES)) begin
                st_nxt.npulse = st_r.npulse + 2'h1;
            end
        end
        st_nxt.sy = (st_r.npulse == 2'(SYNC_PULSES));
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_frame  = st_r.inf;
    assign out_frame = st_r.outf;
    assign synced    = st_r.sy;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_sync_after3: assert property (st_r.sy |-> st_r.npulse == 2'd3)
        else $error("synchronized before three sync pulses");
endmodule : iah_sync
`default_nettype wire

// ==== rtl/iah_top.sv ====
// iah_top: host port with direct and indirect register access
// assumes: host pins asynchronous to mclk, strobes longer than 3 mclk
`timescale 1ns/1ps
`default_nettype none
module iah_top (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire iah_pkg::iah_pins_t pins,
    input  wire logic              sp,
    input  wire logic [7:0]        lk_addr,
    output logic [7:0]             db_out,
    output logic                   db_oe,
    output logic [3:0]             op_mode,
    output logic                   tri_sel,
    output logic                   standby,
    output logic                   clk_sel,
    output logic                   config_std,
    output logic [7:0]             clk_shift,
    output iah_pkg::iah_lk_t       lk,
    output logic                   in_frame,
    output logic                   out_frame,
    output logic                   synced
);
    import iah_pkg::*;

    if (ACCESS_CYC < 1 || ACCESS_CYC > 16) begin : g_chk
        $error("access time does not fit the timer");
    end

    ////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        iah_pins_t  p1;
        iah_pins_t  p2;
        iah_pins_t  p3;
        iah_ia_t    ia;
        logic [3:0] tmr;
        logic       z;
        logic [7:0] ctl;
        logic [7:0] dat;
        logic [7:0] adr;
        logic [7:0] mode;
        logic [7:0] configuration_register;
        logic [7:0] clock_shift_register;
        logic [7:0] dout;
        logic       doe;
        logic       cm_we;
        logic       cm_clr;
    } iah_top_st_t;

    iah_top_st_t st_r;
    iah_top_st_t st_nxt;

    logic [9:0] cm_rd;
    logic       cm_busy;
    logic       wr_end;
    logic       rd_beg;
    logic       rd_end;
    logic       sy;

    function automatic logic is_ind(input logic [7:0] c);
        is_ind = c[CTL_K1] & c[CTL_K0];
    endfunction : is_ind

    function automatic logic [7:0] iar_view(input iah_top_st_t s);
        case (s.ia)
            IA_RDAT: iar_view = s.dat;
            IA_RADR: iar_view = s.adr;
            default: iar_view = s.ctl | CTRL_ONES;
        endcase
    endfunction : iar_view

    ////////////////////////////////////////////////////////////////
    // strobe edges on synchronized pins

    assign wr_end = st_r.p2.wr_n & ~st_r.p3.wr_n & ~st_r.p3.cs_n & st_r.p3.rd_n;
    assign rd_beg = ~st_r.p2.rd_n & st_r.p3.rd_n & ~st_r.p2.cs_n;
    assign rd_end = st_r.doe & (st_r.p2.rd_n | st_r.p2.cs_n);

    ////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;
        st_nxt.p1 = pins;
        st_nxt.p2 = st_r.p1;
        st_nxt.p3 = st_r.p2;
        st_nxt.cm_we = 1'b0;
        st_nxt.cm_clr = 1'b0;

        // direct mode register write
        if (wr_end && !st_r.p3.a0) begin
            st_nxt.mode = st_r.p3.db;
            st_nxt.cm_clr = ~st_r.p3.db[MODE_RC] & ~cm_busy;
        end

        // host reads
        if (rd_beg) begin
            st_nxt.doe = 1'b1;
            if (st_r.p2.a0) begin
                st_nxt.dout = iar_view(st_r);
            end else begin
                st_nxt.dout = {cm_busy, st_r.z, ~sy, 5'h00};
            end
        end else if (rd_end) begin
            st_nxt.doe = 1'b0;
        end

        case (st_r.ia)
            IA_IDLE: begin
                if (wr_end && st_r.p3.a0 && !st_r.mode[MODE_RI]) begin
                    st_nxt.ctl = st_r.p3.db;
                    st_nxt.z = 1'b1;
                    st_nxt.ia = IA_WDAT;
                end
            end
            IA_WDAT: begin
                if (wr_end && st_r.p3.a0) begin
                    st_nxt.dat = st_r.p3.db;
                    st_nxt.ia = IA_WADR;
                end
            end
            IA_WADR: begin
                if (wr_end && st_r.p3.a0) begin
                    st_nxt.adr = st_r.p3.db;
                    st_nxt.tmr = 4'(ACCESS_CYC - 1);
                    st_nxt.ia = IA_ACC;
                end
            end
            IA_ACC: begin
                if (st_r.tmr != 4'h0) begin
                    st_nxt.tmr = st_r.tmr - 4'h1;
                end else begin
                    st_nxt.z = 1'b0;
                    st_nxt.ia = IA_IDLE;
                    if (is_ind(st_r.ctl)) begin
                        if (st_r.ctl[CTL_C0]) begin
                            st_nxt.ia = IA_RCTL;
                            st_nxt.ctl[1:0] = 2'b11;
                            case (st_r.adr)
                                CFR_SEL: st_nxt.dat = st_r.configuration_register | CFR_ONES;
                                CSR_SEL: st_nxt.dat = st_r.clock_shift_register;
                                default: st_nxt.dat = 8'h00;
                            endcase
                        end else if (st_r.adr == CFR_SEL) begin
                            st_nxt.configuration_register = st_r.dat;
                        end else if (st_r.adr == CSR_SEL) begin
                            st_nxt.clock_shift_register = st_r.dat;
                        end
                    end else if (st_r.ctl[CTL_K1] | st_r.ctl[CTL_K0]) begin
                        st_nxt.cm_we = 1'b1;
                    end else begin
                        st_nxt.ia = IA_RCTL;
                        st_nxt.dat = cm_rd[7:0];
                        st_nxt.ctl[1:0] = cm_rd[9:8];
                    end
                end
            end
            IA_RCTL: begin
                if (rd_beg && st_r.p2.a0) begin
                    st_nxt.z = 1'b1;
                end
                if (rd_end && st_r.p3.a0) begin
                    st_nxt.ia = IA_RDAT;
                end
            end
            IA_RDAT: begin
                if (rd_end && st_r.p3.a0) begin
                    st_nxt.ia = IA_RADR;
                end
            end
            IA_RADR: begin
                if (rd_end && st_r.p3.a0) begin
                    st_nxt.tmr = 4'(ACCESS_CYC - 1);
                    st_nxt.ia = IA_REC;
                end
            end
            IA_REC: begin
                if (st_r.tmr != 4'h0) begin
                    st_nxt.tmr = st_r.tmr - 4'h1;
                end else begin
                    st_nxt.z = 1'b0;
                    st_nxt.ia = IA_IDLE;
                end
            end
            default: begin
                st_nxt.ia = IA_IDLE;
            end
        endcase

        // abort of an indirect access
        if (st_r.mode[MODE_RI] && st_r.ia != IA_IDLE) begin
            st_nxt.ia = IA_IDLE;
            st_nxt.z = 1'b0;
            st_nxt.cm_we = 1'b0;
        end

        // software reset: both strobes low
        if (!st_r.p2.wr_n && !st_r.p2.rd_n) begin
            st_nxt.ia = IA_IDLE;
            st_nxt.z = 1'b0;
            st_nxt.tmr = 4'h0;
            st_nxt.mode = MODE_RST;
            st_nxt.configuration_register = CFR_RST;
            st_nxt.clock_shift_register = CSR_RST;
            st_nxt.doe = 1'b0;
            st_nxt.cm_we = 1'b0;
            st_nxt.cm_clr = 1'b0;
        end

        if (st_nxt.configuration_register[CFR_CFS]) begin
            st_nxt.clock_shift_register = 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.p1 <= '1;
            st_r.p2 <= '1;
            st_r.p3 <= '1;
            st_r.mode <= MODE_RST;
            st_r.configuration_register <= CFR_RST;
            st_r.clock_shift_register <= CSR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // connection memory and sync tracking

    iah_cm #(
        .DEPTH (CM_DEPTH)
    ) u_cm (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .we      (st_r.cm_we),
        .waddr   (st_r.adr),
        .wdata   ({st_r.ctl[1:0], st_r.dat}),
        .clr     (st_r.cm_clr),
        .raddr   (st_r.adr),
        .rdata   (cm_rd),
        .lk_addr (lk_addr),
        .lk      (lk),
        .busy    (cm_busy)
    );

    iah_sync u_sync (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .sp        (sp),
        .in_frame  (in_frame),
        .out_frame (out_frame),
        .synced    (sy)
    );

    ////////////////////////////////////////////////////////////////
    // outputs

    assign db_out     = st_r.dout;
    assign db_oe      = st_r.doe;
    assign op_mode    = st_r.mode[MODE_SEL +: 4];
    assign tri_sel    = st_r.mode[MODE_TRI];
    assign standby    = st_r.mode[MODE_STBY];
    assign clk_sel    = st_r.configuration_register[CFR_CLK];
    assign config_std = st_r.configuration_register[CFR_CFS];
    assign clk_shift  = st_r.clock_shift_register;
    assign synced     = sy;

    ////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_req_end;
        st_r.ia == IA_WADR && wr_end && st_r.p3.a0 && !st_r.mode[MODE_RI];
    endsequence

    sequence s_rb_end;
        st_r.ia == IA_RADR && rd_end && st_r.p3.a0 && !st_r.mode[MODE_RI]
            && st_r.p2.wr_n;
    endsequence

    a_first_busy: assert property (st_r.ia == IA_IDLE && wr_end && st_r.p3.a0
        && !st_r.mode[MODE_RI] |=> st_r.z)
        else $error("busy not set on first write");
    a_access_time: assert property (s_req_end ##1 st_r.ia == IA_ACC
        |-> ##[1:9] (st_r.ia != IA_ACC && !st_r.z))
        else $error("indirect access exceeded its time");
    a_readback_busy: assert property (st_r.ia == IA_RCTL && rd_beg && st_r.p2.a0
        && st_r.p2.wr_n |=> st_r.z)
        else $error("busy not set on first read-back");
    a_key_kept: assert property ((st_r.ia == IA_RDAT || st_r.ia == IA_RADR)
        |-> $stable(st_r.adr) && $stable(st_r.ctl[5:4]))
        else $error("type bits or address changed on read-back");
    a_recover_time: assert property (s_rb_end |=> st_r.ia == IA_REC
        ##[1:9] (st_r.ia == IA_IDLE && !st_r.z))
        else $error("recovery exceeded its time");
    a_ctrl_ones: assert property (st_r.ia == IA_RCTL && rd_beg && st_r.p2.a0
        && st_r.p2.wr_n |=> (db_out & 8'hCC) == 8'hCC && db_oe)
        else $error("unused control bits not read as one");
    a_reg_low_ones: assert property (st_r.ia == IA_ACC && st_r.tmr == 4'h0
        && is_ind(st_r.ctl) && st_r.ctl[CTL_C0] && !st_r.mode[MODE_RI]
        && st_r.p2.wr_n |=> st_r.ia == IA_RCTL && st_r.ctl[1:0] == 2'b11)
        else $error("register read control bits not one");
    a_sta_low_zero: assert property (rd_beg && !st_r.p2.a0 && st_r.p2.wr_n
        |=> db_out[4:0] == 5'h00 && db_out[6] == $past(st_r.z))
        else $error("status low bits not zero");
    a_csr_std: assert property (st_r.configuration_register[CFR_CFS] |-> st_r.clock_shift_register == 8'h00)
        else $error("clock shift not zero in standard configuration");
    a_abort_idle: assert property (st_r.mode[MODE_RI] && st_r.ia != IA_IDLE
        |=> st_r.ia == IA_IDLE && !st_r.z)
        else $error("abort did not end indirect access");
endmodule : iah_top
`default_nettype wire
